// *** design/lhoc_pkg.sv ***
package lhoc_pkg;

	// ==========================================================
	// chip modes, one-hot, driven by the mode controller
	typedef enum logic [6:0] {
		LHOC_MODE_INIT     = 7'h01,
		LHOC_MODE_NORMAL   = 7'h02,
		LHOC_MODE_STOP     = 7'h04,
		LHOC_MODE_SLEEP    = 7'h08,
		LHOC_MODE_RESTART  = 7'h10,
		LHOC_MODE_FAILSAFE = 7'h20,
		LHOC_MODE_SWFLASH  = 7'h40
	} lhoc_mode_e;

	// ==========================================================
	// timing, figures in their own unit, counts derived from the clock
	localparam int unsigned LHOC_CLK_KHZ = 100000; // core_clk 100 MHz
	localparam int unsigned LHOC_INIT_MODE_TIMEOUT_MS = 256;
	localparam int unsigned LHOC_MCU_SUPPLY_UV_TIMEOUT_MS = 1024;
	localparam int unsigned LHOC_CNT_W = 27; // holds 102.4e6 cycles
	localparam logic [26:0] LHOC_INIT_MODE_TIMEOUT_CYCLES =
		27'(LHOC_INIT_MODE_TIMEOUT_MS * LHOC_CLK_KHZ);
	localparam logic [26:0] LHOC_MCU_SUPPLY_UV_TIMEOUT_CYCLES =
		27'(LHOC_MCU_SUPPLY_UV_TIMEOUT_MS * LHOC_CLK_KHZ);

	// ==========================================================
	// reset values
	localparam logic LHOC_PIN_LOW = 1'b0; // open drain only ever pulls low
	localparam logic LHOC_OE_N_RST = 1'b1; // released after reset
	localparam logic [26:0] LHOC_CNT_RST = 27'h0000000;
	localparam logic LHOC_WD_CNT_RST = 1'b0;

endpackage : lhoc_pkg

// *** design/lhoc_ctrl.sv ***
module lhoc_ctrl #(
	parameter logic [lhoc_pkg::LHOC_CNT_W-1:0] INIT_TIMEOUT_CYCLES =
		lhoc_pkg::LHOC_INIT_MODE_TIMEOUT_CYCLES,
	parameter logic [lhoc_pkg::LHOC_CNT_W-1:0] UV_TIMEOUT_CYCLES =
		lhoc_pkg::LHOC_MCU_SUPPLY_UV_TIMEOUT_CYCLES
) (
	input wire logic core_clk, // 100 MHz core clock
	input wire logic reset, // synchronous, active high
	input wire lhoc_pkg::lhoc_mode_e chip_mode, // current chip mode, one-hot
	input wire logic battery_ok, // battery above battery_limp_min_threshold
	input wire logic mcu_supply_low, // mcu_supply_rail below selected reset threshold
	input wire logic battery_above_uv_thr, // battery above matching uv timeout threshold
	input wire logic config_strap, // config pin level: 1 = config 1/3, 0 = config 2/4
	input wire logic wd_second_fail_sel, // 1 = act on second watchdog failure
	input wire logic wd_fail, // watchdog failure pulse
	input wire logic wd_trigger_ok, // successful watchdog trigger pulse
	input wire logic spi_lh_on, // SPI activation command pulse
	input wire logic spi_lh_off, // SPI deactivation command pulse
	input wire logic reset_short_vcc, // reset line permanently shorted to supply
	input wire logic reset_short_gnd, // reset line permanently shorted to ground
	input wire logic mcu_thermal_sd, // mcu supply regulator thermal shutdown
	output logic lh_pin_out_reg, // pin output value, always low
	output logic lh_pin_oe_n_reg, // low while the pin is pulled low
	output logic lh_active_reg, // status: output is on
	output logic lh_spi_src_reg, // status: held on by SPI command
	output logic lh_fail_src_reg, // status: held on by a failure
	output logic fail_safe_req_reg, // one-cycle pulse: uv timeout, go fail-safe
	output logic config_24_reg // held configuration: 1 = config 2/4
);
	import lhoc_pkg::*;

	// ==========================================================
	// mode decode
	logic in_init;
	logic in_normal;
	logic in_restart;
	logic in_failsafe;
	assign in_init = (chip_mode == LHOC_MODE_INIT);
	assign in_normal = (chip_mode == LHOC_MODE_NORMAL);
	assign in_restart = (chip_mode == LHOC_MODE_RESTART);
	assign in_failsafe = (chip_mode == LHOC_MODE_FAILSAFE);

	// ==========================================================
	// init mode timer
	logic [LHOC_CNT_W-1:0] init_cnt_reg;
	logic init_expired_reg;
	logic init_fire;
	assign init_fire = in_init && !init_expired_reg &&
		(init_cnt_reg == INIT_TIMEOUT_CYCLES - 27'h0000001);

	// counts only while in init; a fresh init restarts the window
	always_ff @(posedge core_clk) begin
		if (reset || !in_init) begin
			init_cnt_reg <= LHOC_CNT_RST;
			init_expired_reg <= 1'b0;
		end else if (init_fire) begin
			init_expired_reg <= 1'b1;
		end else if (!init_expired_reg) begin
			init_cnt_reg <= init_cnt_reg + 27'h0000001;
		end
	end

	// ==========================================================
	// configuration strap, latched only in init
	always_ff @(posedge core_clk) begin
		if (reset) begin
			config_24_reg <= 1'b0;
		end else if (in_init) begin
			config_24_reg <= !config_strap;
		end
	end

	// ==========================================================
	// mcu supply undervoltage timeout
	logic [LHOC_CNT_W-1:0] uv_cnt_reg;
	logic uv_cond;
	logic uv_timeout;
	assign uv_cond = mcu_supply_low && battery_above_uv_thr;
	assign uv_timeout = uv_cond && (uv_cnt_reg == UV_TIMEOUT_CYCLES);

	// saturates one past the timeout so the event fires once per episode
	always_ff @(posedge core_clk) begin
		if (reset || !uv_cond) begin
			uv_cnt_reg <= LHOC_CNT_RST;
		end else if (uv_cnt_reg <= UV_TIMEOUT_CYCLES) begin
			uv_cnt_reg <= uv_cnt_reg + 27'h0000001;
		end
	end

	// fail-safe request pulse to the mode controller
	always_ff @(posedge core_clk) begin
		if (reset) begin
			fail_safe_req_reg <= 1'b0;
		end else begin
			fail_safe_req_reg <= uv_timeout;
		end
	end

	// ==========================================================
	// watchdog failure counter, only meaningful in normal mode
	logic wd_cnt_reg;
	logic wd_act;
	assign wd_act = in_normal && wd_fail && (!wd_second_fail_sel || wd_cnt_reg);

	always_ff @(posedge core_clk) begin
		if (reset || !in_normal || wd_trigger_ok) begin
			wd_cnt_reg <= LHOC_WD_CNT_RST;
		end else if (wd_fail) begin
			wd_cnt_reg <= 1'b1;
		end
	end

	// ==========================================================
	// release sequence tracking
	logic prev_restart_reg;
	logic from_restart_reg;
	logic wd_ok_seen_reg;
	logic fail_release;
	assign fail_release = in_normal && from_restart_reg && wd_ok_seen_reg && spi_lh_off;

	// remember that normal mode was reached straight from restart
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prev_restart_reg <= 1'b0;
			from_restart_reg <= 1'b0;
		end else begin
			prev_restart_reg <= in_restart;
			if (!in_normal) begin
				from_restart_reg <= 1'b0;
			end else if (prev_restart_reg) begin
				from_restart_reg <= 1'b1;
			end
		end
	end

	// a good trigger after restart arms the release, output stays on
	always_ff @(posedge core_clk) begin
		if (reset || !in_normal || fail_release) begin
			wd_ok_seen_reg <= 1'b0;
		end else if (from_restart_reg && wd_trigger_ok) begin
			wd_ok_seen_reg <= 1'b1;
		end
	end

	// ==========================================================
	// activation sources; a set in the same cycle as a clear wins
	logic fail_set;
	logic spi_set;
	logic init_clear;
	logic spi_src_next;
	logic fail_src_next;
	assign fail_set = battery_ok && (init_fire
		|| wd_act
		|| (in_restart && (reset_short_vcc || reset_short_gnd))
		|| uv_timeout
		|| mcu_thermal_sd
		|| in_failsafe);
	assign spi_set = battery_ok && in_normal && spi_lh_on;
	// init without timeout starts from off
	assign init_clear = in_init && !init_expired_reg;

	always_comb begin
		spi_src_next = lh_spi_src_reg;
		fail_src_next = lh_fail_src_reg;
		if (init_clear) begin
			spi_src_next = 1'b0;
			fail_src_next = 1'b0;
		end
		if (spi_lh_off) begin
			spi_src_next = 1'b0;
		end
		if (fail_release) begin
			fail_src_next = 1'b0;
		end
		if (spi_set) begin
			spi_src_next = 1'b1;
		end
		if (fail_set) begin
			fail_src_next = 1'b1;
		end
	end

	// source flags; outside init and normal only the failure sets and spi_lh_off change them
	always_ff @(posedge core_clk) begin
		if (reset) begin
			lh_spi_src_reg <= 1'b0;
			lh_fail_src_reg <= 1'b0;
		end else begin
			lh_spi_src_reg <= spi_src_next;
			lh_fail_src_reg <= fail_src_next;
		end
	end

	// ==========================================================
	// pin drive; low battery floats the pin but keeps the latched sources
	always_ff @(posedge core_clk) begin
		if (reset) begin
			lh_pin_out_reg <= LHOC_PIN_LOW;
			lh_pin_oe_n_reg <= LHOC_OE_N_RST;
			lh_active_reg <= 1'b0;
		end else begin
			lh_pin_out_reg <= LHOC_PIN_LOW;
			lh_pin_oe_n_reg <= !((spi_src_next || fail_src_next) && battery_ok);
			lh_active_reg <= (spi_src_next || fail_src_next) && battery_ok;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// the pin may only be pulled while a latched source stands behind it
	property p_open_drain;
		lh_pin_out_reg == 1'b0 && lh_active_reg == !lh_pin_oe_n_reg &&
			(lh_pin_oe_n_reg || lh_spi_src_reg || lh_fail_src_reg);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin not open drain");

	property p_low_battery;
		!battery_ok |=> lh_pin_oe_n_reg && !lh_active_reg;
	endproperty
	a_low_battery: assert property (p_low_battery) else $error("pin driven at low battery");

	// no source flag may rise while the battery is below the limp minimum
	property p_low_battery_ignore;
		!battery_ok |=> (lh_spi_src_reg -> $past(lh_spi_src_reg)) &&
			(lh_fail_src_reg -> $past(lh_fail_src_reg));
	endproperty
	a_low_battery_ignore: assert property (p_low_battery_ignore) else $error("request taken");

	property p_spi_on;
		in_normal && spi_lh_on && battery_ok |=> lh_spi_src_reg && !lh_pin_oe_n_reg;
	endproperty
	a_spi_on: assert property (p_spi_on) else $error("SPI activation missed");

	property p_failsafe_on;
		in_failsafe && battery_ok |=> !lh_pin_oe_n_reg;
	endproperty
	a_failsafe_on: assert property (p_failsafe_on) else $error("fail-safe not on");

	// thermal shutdown and uv timeout act in any mode, init included
	property p_init_off;
		in_init && !init_expired_reg && !init_fire && !uv_timeout && !mcu_thermal_sd |=>
			lh_pin_oe_n_reg;
	endproperty
	a_init_off: assert property (p_init_off) else $error("on in init before timeout");

	property p_init_timeout;
		in_init && init_fire && battery_ok |=> lh_fail_src_reg && init_expired_reg;
	endproperty
	a_init_timeout: assert property (p_init_timeout) else $error("init timeout missed");

	property p_wd_second;
		in_normal && wd_fail && wd_second_fail_sel && !wd_cnt_reg && !wd_trigger_ok &&
			!lh_fail_src_reg && !mcu_thermal_sd && !uv_timeout |=>
			!lh_fail_src_reg && wd_cnt_reg;
	endproperty
	a_wd_second: assert property (p_wd_second) else $error("acted on first failure");

	property p_restart_short;
		in_restart && (reset_short_vcc || reset_short_gnd) && battery_ok |=> lh_fail_src_reg;
	endproperty
	a_restart_short: assert property (p_restart_short) else $error("short not acted on");

	property p_spi_hold;
		lh_spi_src_reg && !spi_lh_off && !init_clear |=> lh_spi_src_reg;
	endproperty
	a_spi_hold: assert property (p_spi_hold) else $error("SPI source lost");

	property p_fail_hold;
		lh_fail_src_reg && !fail_release && !init_clear |=> lh_fail_src_reg;
	endproperty
	a_fail_hold: assert property (p_fail_hold) else $error("failure source lost");

	property p_uv_timeout;
		uv_cond && uv_cnt_reg == UV_TIMEOUT_CYCLES - 27'h0000001 ##1 uv_cond |=>
			fail_safe_req_reg ##1 !fail_safe_req_reg;
	endproperty
	a_uv_timeout: assert property (p_uv_timeout) else $error("uv timeout pulse wrong");

	property p_uv_assert;
		uv_timeout && battery_ok |=> fail_safe_req_reg && lh_fail_src_reg;
	endproperty
	a_uv_assert: assert property (p_uv_assert) else $error("uv timeout not acted on");

	property p_config_held;
		!in_init |=> $stable(config_24_reg);
	endproperty
	a_config_held: assert property (p_config_held) else $error("config changed");

	property p_uv_restart;
		!uv_cond |=> uv_cnt_reg == LHOC_CNT_RST;
	endproperty
	a_uv_restart: assert property (p_uv_restart) else $error("uv counter not cleared");

	c_spi_cycle: cover property (spi_set ##[1:50] in_normal && spi_lh_off);
	c_release: cover property (wd_ok_seen_reg && fail_release ##1 lh_pin_oe_n_reg);
	c_uv_timeout: cover property (fail_safe_req_reg);
	c_wd_second: cover property (wd_act && wd_second_fail_sel);

endmodule : lhoc_ctrl

// *** tb/lhoc_pin_model.sv ***
// ====
// board side of the limp-home pin: open drain with an external pull-up
module lhoc_pin_model (
	input wire logic pin_out, // value the block drives
	input wire logic pin_oe_n, // low while the block pulls the pin
	output logic pin_level // resolved board level
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released pin reads the pull-up level, never the last driven value
	assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule : lhoc_pin_model

// *** tb/test_limp_home_output_control.sv ***
// ====
// self-checking bench: host commands and supervisor flags as pulses and levels
module test_limp_home_output_control;
	timeunit 1ns;
	timeprecision 1ns;
	import lhoc_pkg::*;
	localparam logic [3:0] ON = 4'h8;
	localparam logic [3:0] OFF = 4'h4;
	localparam logic [3:0] TRG = 4'h2;
	localparam logic [3:0] WDF = 4'h1;
	logic core_clk = 1'b0;
	logic reset;
	lhoc_mode_e chip_mode;
	logic battery_ok, mcu_supply_low, battery_above_uv_thr, config_strap, wd_second_fail_sel;
	logic reset_short_vcc, reset_short_gnd, mcu_thermal_sd;
	logic [3:0] pls;
	logic lh_pin_out_reg, lh_pin_oe_n_reg, lh_active_reg, lh_spi_src_reg, lh_fail_src_reg;
	logic fail_safe_req_reg, config_24_reg, lh_pin;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	// ====
	// clock, timeout guard
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			complete_run();
		end
	end
	// ====
	// block and board
	lhoc_ctrl #(.INIT_TIMEOUT_CYCLES(27'h0000014), .UV_TIMEOUT_CYCLES(27'h000001E)) dut_u (
		.core_clk(core_clk),
		.reset(reset),
		.chip_mode(chip_mode),
		.battery_ok(battery_ok),
		.mcu_supply_low(mcu_supply_low),
		.battery_above_uv_thr(battery_above_uv_thr),
		.config_strap(config_strap),
		.wd_second_fail_sel(wd_second_fail_sel),
		.wd_fail(pls[0]),
		.wd_trigger_ok(pls[1]),
		.spi_lh_on(pls[3]),
		.spi_lh_off(pls[2]),
		.reset_short_vcc(reset_short_vcc),
		.reset_short_gnd(reset_short_gnd),
		.mcu_thermal_sd(mcu_thermal_sd),
		.lh_pin_out_reg(lh_pin_out_reg),
		.lh_pin_oe_n_reg(lh_pin_oe_n_reg),
		.lh_active_reg(lh_active_reg),
		.lh_spi_src_reg(lh_spi_src_reg),
		.lh_fail_src_reg(lh_fail_src_reg),
		.fail_safe_req_reg(fail_safe_req_reg),
		.config_24_reg(config_24_reg)
	);
	lhoc_pin_model board_u (.pin_out(lh_pin_out_reg), .pin_oe_n(lh_pin_oe_n_reg), .pin_level(lh_pin));
	// ====
	// helpers; all input changes land just after a falling edge
	task automatic complete_run();
		if (fail_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic seen, input logic exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %b expected %b", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask : cyc
	// one-cycle command pulse, then an idle edge so back-to-back calls never
	// lower and raise the strobe in one time step
	task automatic pulse(input logic [3:0] p);
		pls = p;
		cyc(1);
		pls = 4'h0;
		cyc(1);
	endtask : pulse
	// output state seen from flags, enable and the board wire together
	task automatic chk_on(input logic exp);
		chk(lh_active_reg, exp);
		chk(lh_pin_oe_n_reg, !exp);
		chk(lh_pin, !exp);
		chk(lh_pin_out_reg, 1'b0);
	endtask : chk_on
	task automatic rst(input lhoc_mode_e m);
		chip_mode = m;
		reset = 1'b1;
		cyc(5);
		reset = 1'b0;
		chk_on(1'b0);
		chk(lh_spi_src_reg | lh_fail_src_reg, 1'b0);
	endtask : rst
	// ====
	// scenarios
	initial begin
		{battery_ok, mcu_supply_low, battery_above_uv_thr, config_strap} = 4'h8;
		{wd_second_fail_sel, reset_short_vcc, reset_short_gnd, mcu_thermal_sd} = 4'h0;
		pls = 4'h0;
		// init timeout, strap capture, then the failure release sequence
		rst(LHOC_MODE_INIT);
		cyc(19);
		chk_on(1'b0);
		cyc(2);
		chk_on(1'b1);
		chk(config_24_reg, 1'b1);
		config_strap = 1'b1;
		chip_mode = LHOC_MODE_RESTART;
		cyc(3);
		chk(config_24_reg, 1'b1);
		chk_on(1'b1);
		chip_mode = LHOC_MODE_NORMAL;
		cyc(2);
		pulse(OFF); // host skips the trigger on purpose
		chk_on(1'b1);
		pulse(TRG);
		chk_on(1'b1);
		pulse(OFF);
		chk_on(1'b0);
		// command source: on, kept across sleep, off by command
		rst(LHOC_MODE_NORMAL);
		pulse(ON);
		chk_on(1'b1);
		chk(lh_spi_src_reg, 1'b1);
		chip_mode = LHOC_MODE_SLEEP;
		pulse(TRG);
		chk_on(1'b1);
		chip_mode = LHOC_MODE_NORMAL;
		pulse(OFF);
		chk_on(1'b0);
		chip_mode = LHOC_MODE_STOP;
		pulse(ON);
		chk_on(1'b0);
		// low battery: requests ignored, a latched source only floats the pin
		chip_mode = LHOC_MODE_NORMAL;
		battery_ok = 1'b0;
		pulse(ON);
		chk_on(1'b0);
		battery_ok = 1'b1;
		cyc(1);
		chk_on(1'b0);
		pulse(ON);
		battery_ok = 1'b0;
		cyc(1);
		chk_on(1'b0);
		chk(lh_spi_src_reg, 1'b1);
		battery_ok = 1'b1;
		cyc(1);
		chk_on(1'b1);
		// watchdog failures, first or second, trigger clears the tally
		for (int s = 0; s < 2; s++) begin
			rst(LHOC_MODE_NORMAL);
			wd_second_fail_sel = s[0];
			pulse(WDF);
			pulse(TRG);
			pulse(WDF);
			chk_on(!s[0]);
			pulse(WDF);
			chk_on(1'b1);
		end
		// reset-line shorts in restart, thermal shutdown in stop
		for (int k = 0; k < 3; k++) begin
			rst(lhoc_mode_e'(k == 2 ? LHOC_MODE_STOP : LHOC_MODE_RESTART));
			{reset_short_vcc, reset_short_gnd, mcu_thermal_sd} = 3'h4 >> k;
			cyc(2);
			chk_on(1'b1);
			chk(lh_fail_src_reg, 1'b1);
			{reset_short_vcc, reset_short_gnd, mcu_thermal_sd} = 3'h0;
		end
		rst(LHOC_MODE_FAILSAFE);
		cyc(1);
		chk_on(1'b1);
		// undervoltage timer: a drop restarts it, then one request pulse
		rst(LHOC_MODE_NORMAL);
		{mcu_supply_low, battery_above_uv_thr} = 2'h3;
		cyc(20);
		battery_above_uv_thr = 1'b0;
		cyc(1);
		battery_above_uv_thr = 1'b1;
		cyc(29);
		chk(fail_safe_req_reg, 1'b0);
		chk_on(1'b0);
		n = 0;
		// condition has now stood 29 edges; count edge 30 detects, the next one pulses
		while (fail_safe_req_reg !== 1'b1 && n < 5) begin
			cyc(1);
			n++;
		end
		chk(n == 2, 1'b1);
		cyc(1);
		chk(fail_safe_req_reg, 1'b0);
		chk_on(1'b1);
		complete_run();
	end
endmodule : test_limp_home_output_control
